// ---- rtl/mdsa_top.sv ----
/*
  Control-side logic of a brushless motor drive: control terminal decode,
  two assignable status outputs, register port and addressed serial link.
  Assumes a motor core that takes the commands and reports its status.
*/
// How it works
// - Serial link fixed at 9600 bit/s.
// - One host, up to sixteen drives.
// - Four-wire host transmitter never released.
// - Address value maps to characters '0' to '?'.
// - Enable energizes; disable-then-enable clears alarms.
// - Stop method: decelerate or short phases.
// - Stop request uses selected stop method.
// - Three speed inputs form one code.
// - Speed pulses per revolution, default six.
// - Motion output active while rotating.
// - Speed reached when within error window.
// - Secondary fault: warning or alarm, normally closed.
// - Warning output follows warning condition.
// - Torque-limit output when torque hits limit.
// - Each output picks one of eight functions.
// - Input ON means photocoupler conducts.
// - Inactive enable overrides the stop inputs; direction and speed still follow.
// - Code zero internal or analog by source select, else preset speeds.
// - Window up to 400 rpm, reset 200.
`timescale 1ns/1ps
`include "mdsa_defs.svh"

module mdsa_top import mdsa_pkg::*; #(
  parameter int BIT_CYCLES = `MDSA_CLK_HZ / `MDSA_BAUD_BPS
) (
  // Clock, reset, clock enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Control terminals, bit 0 is control_in_1
  input wire logic [7:0] control_in,
  // Motor core status
  input wire logic motor_rotating,
  input wire logic angle_tick,
  input wire logic drive_fault,
  input wire logic overload_over_warn,
  input wire logic overload_alarm,
  input wire logic warning_active,
  input wire logic torque_limit_hit,
  input wire logic [12:0] speed_meas_rpm,
  input wire logic [12:0] internal_rpm,
  input wire logic [12:0] analog_rpm,
  // Motor core commands
  output logic motor_energize,
  output logic brake_short,
  output logic decel_stop,
  output logic direction_ccw,
  output logic speed_source_ext,
  output logic [2:0] speed_code,
  output logic [12:0] speed_cmd_rpm,
  output logic alarm_clear,
  // Status outputs
  output logic status_out_a,
  output logic status_out_b,
  // Serial pins
  input wire logic ser_rx,
  output logic ser_tx,
  output logic ser_tx_oe_n,
  // Command and reply stream
  output logic [7:0] cmd_byte,
  output logic cmd_valid,
  output logic cmd_end,
  input wire logic [7:0] reply_byte,
  input wire logic reply_valid,
  output logic reply_ready
);

  localparam logic [13:0] BITC = 14'(BIT_CYCLES);
  localparam logic [13:0] HALFC = 14'(BIT_CYCLES / 2);

  mdsa_din_if din ();

  // Inputs are ON/OFF photocoupler states; the filter makes them clean levels.
  assign din.raw = control_in;

  mdsa_debounce u_deb (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .din(din)
  );

  // Named terminal functions.
  wire direction_select = din.clean[0];
  wire stop_method_select = din.clean[1];
  wire enable_alarm_clear = din.clean[2];
  wire speed_source_select = din.clean[3];
  wire stop_request = din.clean[4];
  wire [2:0] code_d = {din.clean[7], din.clean[6], din.clean[5]};

  // Registers and state.
  logic warn_en_q;
  logic [1:0] gp_q;
  mdsa_out_func_type sel_a_q;
  mdsa_out_func_type sel_b_q;
  logic [7:0] ppr_q;
  logic [8:0] window_q;
  logic [3:0] addr_q;
  logic en_prev_q;
  logic alarm_q;
  logic [9:0] acc_q;
  logic pulse_q;
  logic [1:0] rx_sync_q;
  mdsa_rx_state_type rx_st_q;
  logic [13:0] rx_cnt_q;
  logic [2:0] rx_idx_q;
  logic [7:0] rx_sh_q;
  logic rx_done_q;
  mdsa_frame_state_type fr_q;
  logic addressed_q;
  logic tx_busy_q;
  logic [8:0] tx_sh_q;
  logic [3:0] tx_bits_q;
  logic [13:0] tx_cnt_q;
  // Declared here because the status word reads it before its compare is built.
  wire speed_reached;

  // Register decode and clamped write values.
  wire wr_ctrl = reg_wr && reg_addr == `MDSA_OFF_CTRL;
  wire wr_outsel = reg_wr && reg_addr == `MDSA_OFF_OUTSEL;
  wire wr_ppr = reg_wr && reg_addr == `MDSA_OFF_PPR;
  wire wr_window = reg_wr && reg_addr == `MDSA_OFF_WINDOW;
  wire wr_addr = reg_wr && reg_addr == `MDSA_OFF_ADDR;
  wire [7:0] ppr_w = reg_wdata[7:0] == 8'h00 ? 8'h01 :
                     reg_wdata[7:0] > `MDSA_PPR_MAX ? `MDSA_PPR_MAX : reg_wdata[7:0];
  wire win_big = reg_wdata[31:9] != 23'h000000 || reg_wdata[8:0] > `MDSA_WINDOW_MAX;
  wire [8:0] window_w = win_big ? `MDSA_WINDOW_MAX : reg_wdata[8:0];
  wire [31:0] status_word = {18'h00000, warning_active, alarm_q, addressed_q, tx_busy_q,
                             motor_rotating, speed_reached, din.clean};
  wire [31:0] rd_mux =
    reg_addr == `MDSA_OFF_CTRL ? {29'h00000000, gp_q, warn_en_q} :
    reg_addr == `MDSA_OFF_OUTSEL ? {25'h0000000, sel_b_q, 1'b0, sel_a_q} :
    reg_addr == `MDSA_OFF_PPR ? {24'h000000, ppr_q} :
    reg_addr == `MDSA_OFF_WINDOW ? {23'h000000, window_q} :
    reg_addr == `MDSA_OFF_ADDR ? {28'h0000000, addr_q} :
    reg_addr == `MDSA_OFF_STATUS ? status_word : 32'h00000000;

  // Software settings; read data stand only in the cycle after the read strobe.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      warn_en_q <= 1'b0;
      gp_q <= 2'h0;
      sel_a_q <= FN_FAULT;
      sel_b_q <= FN_SPEED_PULSE;
      ppr_q <= `MDSA_PPR_RESET;
      window_q <= `MDSA_WINDOW_RESET;
      addr_q <= 4'h0;
      reg_rdata <= 32'h00000000;
    end else if (ce) begin
      if (wr_ctrl) begin
        warn_en_q <= reg_wdata[`MDSA_CTRL_WARN_EN];
        gp_q <= reg_wdata[`MDSA_CTRL_GP_B:`MDSA_CTRL_GP_A];
      end
      if (wr_outsel) begin
        sel_a_q <= mdsa_out_func_type'(reg_wdata[2:0]);
        sel_b_q <= mdsa_out_func_type'(reg_wdata[`MDSA_OUTSEL_B_LSB +: 3]);
      end
      if (wr_ppr) ppr_q <= ppr_w;
      if (wr_window) window_q <= window_w;
      if (wr_addr) addr_q <= reg_wdata[3:0];
      reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
    end
  end

  // Drive commands; a low enable forces energize and both stop commands off, acting as emergency stop.
  wire en_rise = enable_alarm_clear && !en_prev_q;
  wire alarm_d = drive_fault || (alarm_q && !en_rise);
  wire [12:0] preset_rpm =
    code_d == 3'h1 ? `MDSA_RPM_1 : code_d == 3'h2 ? `MDSA_RPM_2 :
    code_d == 3'h3 ? `MDSA_RPM_3 : code_d == 3'h4 ? `MDSA_RPM_4 :
    code_d == 3'h5 ? `MDSA_RPM_5 : code_d == 3'h6 ? `MDSA_RPM_6 : `MDSA_RPM_7;
  wire [12:0] base_rpm = speed_source_select ? analog_rpm : internal_rpm;
  wire [12:0] cmd_rpm_d = code_d == 3'h0 ? base_rpm : preset_rpm;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      en_prev_q <= 1'b0;
      alarm_q <= 1'b0;
      alarm_clear <= 1'b0;
      motor_energize <= 1'b0;
      brake_short <= 1'b0;
      decel_stop <= 1'b0;
      direction_ccw <= 1'b0;
      speed_source_ext <= 1'b0;
      speed_code <= 3'h0;
      speed_cmd_rpm <= 13'h0000;
    end else if (ce) begin
      en_prev_q <= enable_alarm_clear;
      alarm_q <= alarm_d;
      alarm_clear <= en_rise;
      motor_energize <= enable_alarm_clear;
      brake_short <= enable_alarm_clear && stop_request && stop_method_select;
      decel_stop <= enable_alarm_clear && stop_request && !stop_method_select;
      direction_ccw <= direction_select;
      speed_source_ext <= speed_source_select;
      speed_code <= code_d;
      speed_cmd_rpm <= cmd_rpm_d;
    end
  end

  // Speed pulses: each angle tick adds twice the pulse count; a wrap toggles the output.
  // Counts above 180 per revolution would need two toggles per tick, so writes clamp.
  wire [9:0] acc_sum = acc_q + {1'b0, ppr_q, 1'b0};
  wire acc_wrap = acc_sum >= `MDSA_ANGLE_TICKS;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      acc_q <= 10'h000;
      pulse_q <= 1'b0;
    end else if (ce && angle_tick) begin
      acc_q <= acc_wrap ? acc_sum - `MDSA_ANGLE_TICKS : acc_sum;
      pulse_q <= pulse_q ^ acc_wrap;
    end
  end

  // Output functions and their selection.
  wire [12:0] speed_diff = speed_meas_rpm >= speed_cmd_rpm ?
                           speed_meas_rpm - speed_cmd_rpm : speed_cmd_rpm - speed_meas_rpm;
  assign speed_reached = speed_diff <= {4'h0, window_q};
  wire secondary_fault = warn_en_q ? overload_over_warn : overload_alarm;
  wire [6:0] fn_common = {torque_limit_hit, warning_active, !secondary_fault,
                          speed_reached, motor_rotating, pulse_q, alarm_q};
  wire [7:0] fn_a = {gp_q[0], fn_common};
  wire [7:0] fn_b = {gp_q[1], fn_common};

  always_ff @(posedge clk) begin
    if (!resetn) begin
      status_out_a <= 1'b0;
      status_out_b <= 1'b0;
    end else if (ce) begin
      status_out_a <= fn_a[sel_a_q];
      status_out_b <= fn_b[sel_b_q];
    end
  end

  // Receiver: the raw pin passes two flip-flops, then a start bit is checked at mid-bit.
  wire rx_level = rx_sync_q[1];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_sync_q <= 2'b11;
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= 14'h0000;
      rx_idx_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_done_q <= 1'b0;
    end else if (ce) begin
      rx_sync_q <= {rx_sync_q[0], ser_rx};
      rx_done_q <= 1'b0;
      if (rx_cnt_q != 14'h0000) begin
        rx_cnt_q <= rx_cnt_q - 14'h0001;
      end else begin
        case (rx_st_q)
          RX_IDLE: begin
            if (!rx_level) begin
              rx_st_q <= RX_START;
              rx_cnt_q <= HALFC;
            end
          end
          RX_START: begin
            rx_st_q <= rx_level ? RX_IDLE : RX_DATA;
            rx_cnt_q <= rx_level ? 14'h0000 : BITC;
            rx_idx_q <= 3'h0;
          end
          RX_DATA: begin
            rx_sh_q <= {rx_level, rx_sh_q[7:1]};
            rx_cnt_q <= BITC;
            rx_idx_q <= rx_idx_q + 3'h1;
            if (rx_idx_q == 3'h7) rx_st_q <= RX_STOP;
          end
          RX_STOP: begin
            rx_st_q <= RX_IDLE;
            rx_done_q <= rx_level;
          end
          default: rx_st_q <= RX_IDLE;
        endcase
      end
    end
  end

  // Framing: the first character names the drive; other drives skip to the carriage return.
  wire [7:0] own_char = {`MDSA_ADDR_BASE, addr_q};
  wire is_cr = rx_sh_q == `MDSA_CHAR_CR;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      fr_q <= FR_IDLE;
      addressed_q <= 1'b0;
      cmd_byte <= 8'h00;
      cmd_valid <= 1'b0;
      cmd_end <= 1'b0;
    end else if (ce) begin
      cmd_valid <= 1'b0;
      cmd_end <= 1'b0;
      if (rx_done_q) begin
        case (fr_q)
          FR_IDLE: begin
            if (!is_cr) addressed_q <= 1'b0;
            if (rx_sh_q == own_char) fr_q <= FR_MINE;
            else if (!is_cr) fr_q <= FR_SKIP;
          end
          FR_MINE: begin
            cmd_byte <= rx_sh_q;
            cmd_valid <= !is_cr;
            cmd_end <= is_cr;
            if (is_cr) begin
              fr_q <= FR_IDLE;
              addressed_q <= 1'b1;
            end
          end
          FR_SKIP: begin
            if (is_cr) fr_q <= FR_IDLE;
          end
          default: fr_q <= FR_IDLE;
        endcase
      end
    end
  end

  // Transmitter drives the pin only while sending, so a shared pair stays free otherwise.
  wire tx_go = reply_valid && reply_ready;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_busy_q <= 1'b0;
      tx_sh_q <= 9'h1FF;
      tx_bits_q <= 4'h0;
      tx_cnt_q <= 14'h0000;
      ser_tx <= 1'b1;
      ser_tx_oe_n <= 1'b1;
      reply_ready <= 1'b0;
    end else if (ce) begin
      reply_ready <= addressed_q && !tx_busy_q && !tx_go;
      if (tx_go) begin
        tx_busy_q <= 1'b1;
        tx_sh_q <= {1'b1, reply_byte};
        tx_bits_q <= 4'h9;
        tx_cnt_q <= BITC;
        ser_tx <= 1'b0;
        ser_tx_oe_n <= 1'b0;
      end else if (tx_busy_q) begin
        if (tx_cnt_q != 14'h0000) begin
          tx_cnt_q <= tx_cnt_q - 14'h0001;
        end else if (tx_bits_q != 4'h0) begin
          ser_tx <= tx_sh_q[0];
          tx_sh_q <= {1'b1, tx_sh_q[8:1]};
          tx_bits_q <= tx_bits_q - 4'h1;
          tx_cnt_q <= BITC;
        end else begin
          tx_busy_q <= 1'b0;
          ser_tx <= 1'b1;
          ser_tx_oe_n <= 1'b1;
        end
      end
    end
  end

endmodule : mdsa_top

// ---- rtl/mdsa_defs.svh ----
/*
  Offsets, field positions, reset values and timing counts of the motor drive
  control-side logic. Assumes inclusion by bare name from the design files.
*/
`ifndef MDSA_DEFS_SVH
`define MDSA_DEFS_SVH

// Clock and serial link timing.
`define MDSA_CLK_HZ 100000000
`define MDSA_BAUD_BPS 9600
`define MDSA_DEBOUNCE_US 10
`define MDSA_DEBOUNCE_CYCLES (`MDSA_DEBOUNCE_US * (`MDSA_CLK_HZ / 1000000))

// Register byte offsets.
`define MDSA_OFF_CTRL 8'h00
`define MDSA_OFF_OUTSEL 8'h04
`define MDSA_OFF_PPR 8'h08
`define MDSA_OFF_WINDOW 8'h0C
`define MDSA_OFF_ADDR 8'h10
`define MDSA_OFF_STATUS 8'h14

// Field positions.
`define MDSA_CTRL_WARN_EN 0
`define MDSA_CTRL_GP_A 1
`define MDSA_CTRL_GP_B 2
`define MDSA_OUTSEL_B_LSB 4

// Reset values and limits.
`define MDSA_PPR_RESET 8'h06
`define MDSA_PPR_MAX 8'hB4
`define MDSA_WINDOW_RESET 9'h0C8
`define MDSA_WINDOW_MAX 9'h190
`define MDSA_ANGLE_TICKS 10'h168

// Preset speeds in rpm for speed codes 1 to 7.
`define MDSA_RPM_1 13'h01F4
`define MDSA_RPM_2 13'h03E8
`define MDSA_RPM_3 13'h07D0
`define MDSA_RPM_4 13'h0BB8
`define MDSA_RPM_5 13'h0DAC
`define MDSA_RPM_6 13'h0FA0
`define MDSA_RPM_7 13'h1194

// Serial characters.
`define MDSA_CHAR_CR 8'h0D
`define MDSA_ADDR_BASE 4'h3

`endif

// ---- rtl/mdsa_pkg.sv ----
/*
  Types of the motor drive control-side logic: state and function encodings.
  Assumes nothing of its surroundings.
*/
package mdsa_pkg;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } mdsa_rx_state_type;

  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_MINE = 2'b01,
    FR_SKIP = 2'b10
  } mdsa_frame_state_type;

  typedef enum logic [2:0] {
    FN_FAULT = 3'b000,
    FN_SPEED_PULSE = 3'b001,
    FN_MOTION = 3'b010,
    FN_SPEED_REACHED = 3'b011,
    FN_SECONDARY_FAULT = 3'b100,
    FN_WARNING = 3'b101,
    FN_TORQUE_LIMIT = 3'b110,
    FN_IDLE = 3'b111
  } mdsa_out_func_type;

endpackage : mdsa_pkg

// ---- rtl/mdsa_din_if.sv ----
/*
  Carrier between the control-input filter and the top: raw terminal levels in,
  clean levels out. Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps

interface mdsa_din_if;
  logic [7:0] raw;
  logic [7:0] clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface : mdsa_din_if

// ---- rtl/mdsa_debounce.sv ----
/*
  Synchroniser and debounce filter for the eight control terminals.
  Assumes terminal levels are already ON/OFF photocoupler states.
*/
`timescale 1ns/1ps
`include "mdsa_defs.svh"

module mdsa_debounce import mdsa_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Terminal levels
  mdsa_din_if.filt din
);

  localparam logic [9:0] DEB_LAST = 10'(`MDSA_DEBOUNCE_CYCLES - 1);

  logic [7:0] s1_q;
  logic [7:0] s2_q;
  logic [7:0] clean_q;
  logic [9:0] cnt_q [8];

  assign din.clean = clean_q;

  // A level must hold steady for the whole window before it is taken; chatter restarts it.
  for (genvar i = 0; i < 8; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (!resetn) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
        clean_q[i] <= 1'b0;
        cnt_q[i] <= 10'h000;
      end else if (ce) begin
        s1_q[i] <= din.raw[i];
        s2_q[i] <= s1_q[i];
        if (s2_q[i] == clean_q[i]) begin
          cnt_q[i] <= 10'h000;
        end else if (cnt_q[i] == DEB_LAST) begin
          clean_q[i] <= s2_q[i];
          cnt_q[i] <= 10'h000;
        end else begin
          cnt_q[i] <= cnt_q[i] + 10'h001;
        end
      end
    end
  end

endmodule : mdsa_debounce

// ---- dv/mdsa_top_assertions.sv ----
/*
  Concurrent checks on the ports of the motor drive control-side logic.
  Assumes it is bound into mdsa_top and that ce is held high by the bench.
*/
`timescale 1ns/1ps
`include "mdsa_defs.svh"

module mdsa_top_assertions #(
  parameter int BIT_CYCLES = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Register port
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Motor commands
  input wire logic motor_energize,
  input wire logic brake_short,
  input wire logic decel_stop,
  input wire logic alarm_clear,
  input wire logic [2:0] speed_code,
  input wire logic [12:0] speed_cmd_rpm,
  // Serial side
  input wire logic ser_tx,
  input wire logic ser_tx_oe_n,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_end,
  input wire logic reply_valid,
  input wire logic reply_ready
);
  // A whole reply frame must fit in this many cycles, with margin for bit stretch.
  localparam int FRAME_MAX = 12 * (BIT_CYCLES + 1);
  localparam logic [12:0] RPM_TAB [8] = '{13'h0000, `MDSA_RPM_1, `MDSA_RPM_2, `MDSA_RPM_3,
    `MDSA_RPM_4, `MDSA_RPM_5, `MDSA_RPM_6, `MDSA_RPM_7};
  logic [12:0] rpm_exp;

  // Preset speed expected for the current code.
  assign rpm_exp = RPM_TAB[speed_code];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  rdata_idle_zero_a: assert property ($past(ce) && !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  stop_needs_enable_a: assert property (brake_short || decel_stop |-> motor_energize)
    else $error("stop command while motor disabled");
  stop_method_excl_a: assert property (!(brake_short && decel_stop))
    else $error("both stop methods at once");
  clear_on_enable_a: assert property (alarm_clear |-> $rose(motor_energize))
    else $error("alarm clear without enable edge");
  clear_one_cycle_a: assert property (alarm_clear |=> !alarm_clear)
    else $error("alarm clear longer than one cycle");
  tx_idle_high_a: assert property (ser_tx_oe_n |-> ser_tx)
    else $error("serial out low while released");
  reply_start_bit_a: assert property (reply_valid && reply_ready |=>
    !ser_tx && !ser_tx_oe_n && !reply_ready)
    else $error("reply not started after being taken");
  start_bit_len_a: assert property ($fell(ser_tx) |-> !ser_tx [*8])
    else $error("start bit too short");
  frame_length_a: assert property ($fell(ser_tx_oe_n) |-> ##[1:FRAME_MAX] ser_tx_oe_n)
    else $error("transmitter held too long");
  ready_tx_idle_a: assert property (reply_ready |-> ser_tx_oe_n)
    else $error("ready while transmitting");
  cmd_end_cr_a: assert property (cmd_end |-> cmd_byte == `MDSA_CHAR_CR)
    else $error("frame end without carriage return");
  preset_speed_a: assert property ($stable(speed_code) && speed_code != 3'h0
    |-> speed_cmd_rpm == rpm_exp)
    else $error("preset speed mismatch");

  alarm_clear_c: cover property (alarm_clear);
  frame_end_c: cover property (cmd_end);
  reply_taken_c: cover property (reply_valid && reply_ready);
  brake_stop_c: cover property (brake_short);
endmodule : mdsa_top_assertions

bind mdsa_top mdsa_top_assertions #(.BIT_CYCLES(BIT_CYCLES)) i_mdsa_top_assertions (
  .clk, .resetn, .ce, .reg_rd, .reg_rdata, .motor_energize, .brake_short, .decel_stop,
  .alarm_clear, .speed_code, .speed_cmd_rpm, .ser_tx, .ser_tx_oe_n, .cmd_byte, .cmd_end,
  .reply_valid, .reply_ready);

// ---- dv/mdsa_host_model.sv ----
/*
  Serial host on the drive bus: sends 8N1 characters and collects replies.
  Assumes a separate receive pair, so the host line idles at mark between frames.
*/
`timescale 1ns/1ps

module mdsa_host_model #(
  parameter int BIT_CYCLES = 32
) (
  // Clock
  input wire logic clk,
  // Serial lines, host side
  output logic host_tx,
  input wire logic drive_tx
);
  logic [7:0] rx_byte = 8'h00;
  logic [7:0] rx_shift = 8'h00;
  int rx_count = 0;

  // The host line rests at mark and is never released, since replies use their own pair.
  initial host_tx = 1'b1;

  // One character at the fixed bit time, start bit, LSB first, stop bit.
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      host_tx <= frame[i];
      repeat (BIT_CYCLES - 1) @(posedge clk);
    end
  endtask : send_byte

  // Receiver samples mid-bit; each step is one bit time plus a cycle, following the drive's bit stretch.
  always begin
    @(negedge drive_tx);
    repeat (BIT_CYCLES / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES + 1) @(posedge clk);
      rx_shift[i] = drive_tx;
    end
    repeat (BIT_CYCLES) @(posedge clk);
    rx_byte = rx_shift;
    rx_count++;
  end
endmodule : mdsa_host_model

// ---- dv/mdsa_top_test.sv ----
/*
  Self-checking bench of the motor drive control-side logic.
  Assumes the design, its package, the host model and the checker are compiled first.
*/
`timescale 1ns/1ps
`include "mdsa_defs.svh"

module mdsa_top_test;
  localparam int BITS = 32;
  logic clk = 1'b0, resetn = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, control_in = 8'h00, reply_byte = 8'h00, last_cmd = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd;
  logic motor_rotating = 1'b0, angle_tick = 1'b0, drive_fault = 1'b0, overload_alarm = 1'b0;
  logic overload_over_warn = 1'b0, warning_active = 1'b0, torque_limit_hit = 1'b0;
  logic [12:0] speed_meas_rpm = 13'h0000, internal_rpm = 13'h0456, analog_rpm = 13'h0123;
  logic motor_energize, brake_short, decel_stop, direction_ccw, speed_source_ext, alarm_clear;
  logic [2:0] speed_code, f3;
  logic [12:0] speed_cmd_rpm;
  logic status_out_a, status_out_b, host_line, ser_tx, ser_tx_oe_n, prev;
  logic [7:0] cmd_byte;
  logic cmd_valid, cmd_end, reply_valid = 1'b0, reply_ready;
  int n_errors = 0, num_checks = 0, n_clear = 0, n_end = 0, n_tog, k;
  logic [7:0] ci [5] = '{8'h04, 8'h16, 8'h14, 8'h0D, 8'h12};
  logic [4:0] ce5 [5] = '{5'h10, 5'h18, 5'h14, 5'h13, 5'h00};
  logic [12:0] rpm [8] = '{13'h0123, `MDSA_RPM_1, `MDSA_RPM_2, `MDSA_RPM_3, `MDSA_RPM_4,
    `MDSA_RPM_5, `MDSA_RPM_6, `MDSA_RPM_7};
  logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
  logic [31:0] rv [6] = '{32'h0, 32'h10, 32'h6, 32'hC8, 32'h0, 32'h0};
  logic [31:0] cw [4] = '{32'h0, 32'hC8, 32'h1F4, 32'h190};
  logic [31:0] cx [4] = '{32'h1, 32'hB4, 32'h190, 32'h190};

  // Clock at 100 MHz.
  always #5 clk = ~clk;

  mdsa_top #(.BIT_CYCLES(BITS)) i_mdsa_top (.clk, .resetn, .ce, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .control_in, .motor_rotating, .angle_tick, .drive_fault,
    .overload_over_warn, .overload_alarm, .warning_active, .torque_limit_hit,
    .speed_meas_rpm, .internal_rpm, .analog_rpm, .motor_energize, .brake_short, .decel_stop,
    .direction_ccw, .speed_source_ext, .speed_code, .speed_cmd_rpm, .alarm_clear,
    .status_out_a, .status_out_b, .ser_rx(host_line), .ser_tx, .ser_tx_oe_n, .cmd_byte,
    .cmd_valid, .cmd_end, .reply_byte, .reply_valid, .reply_ready);

  mdsa_host_model #(.BIT_CYCLES(BITS)) i_mdsa_host_model (.clk, .host_tx(host_line),
    .drive_tx(ser_tx));

  // Event counters for one-cycle pulses, which a sequence of calls could miss.
  always @(posedge clk) begin
    if (alarm_clear === 1'b1) n_clear <= n_clear + 1;
    if (cmd_end === 1'b1) n_end <= n_end + 1;
    if (cmd_valid === 1'b1 && cmd_byte !== `MDSA_CHAR_CR) last_cmd <= cmd_byte;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    if (n_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  // Debounce plus synchroniser latency, with a small margin.
  task automatic settle();
    repeat (1010) @(posedge clk);
  endtask : settle

  task automatic send_frame(input logic [7:0] a, input logic [7:0] c);
    i_mdsa_host_model.send_byte(a);
    i_mdsa_host_model.send_byte(c);
    i_mdsa_host_model.send_byte(`MDSA_CHAR_CR);
    repeat (4) @(posedge clk);
  endtask : send_frame

  // Watchdog sized at about twice the expected run.
  initial begin
    #800000;
    n_errors++;
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    reg_write(8'h18, 32'hFFFF_FFFF);
    for (int i = 0; i < 6; i++) begin
      reg_read(ra[i], rd);
      chk(rd, rv[i]);
    end
    for (int i = 0; i < 4; i++) begin
      reg_write((i < 1) ? 8'h08 : (i < 2) ? 8'h08 : 8'h0C, cw[i]);
      reg_read((i < 2) ? 8'h08 : 8'h0C, rd);
      chk(rd, cx[i]);
    end
    control_in <= 8'h04;
    repeat (500) @(posedge clk);
    control_in <= 8'h00;
    settle();
    chk(motor_energize, 1'b0);
    for (int i = 0; i < 5; i++) begin
      control_in <= ci[i];
      settle();
      chk({motor_energize, brake_short, decel_stop, direction_ccw, speed_source_ext},
        ce5[i]);
    end
    chk(n_clear, 1);
    for (int c = 0; c < 8; c++) begin
      control_in <= {3'(c), 5'h0C};
      settle();
      chk(speed_code, c);
      chk(speed_cmd_rpm, rpm[c]);
    end
    control_in <= 8'hE4;
    speed_meas_rpm <= `MDSA_RPM_7;
    motor_rotating <= 1'b1;
    torque_limit_hit <= 1'b1;
    overload_over_warn <= 1'b1;
    reg_write(8'h00, 32'h3);
    settle();
    for (int f = 0; f < 8; f++) begin
      f3 = 3'(f);
      reg_write(8'h04, {25'h0, f3, 1'b0, f3});
      repeat (3) @(posedge clk);
      if (f != 1) chk(status_out_a, 8'hCC >> f & 8'h01);
      if (f != 1) chk(status_out_b, (f == 7) ? 1'b0 : 8'hCC >> f & 8'h01);
    end
    // With warning disabled the secondary fault follows the alarm input, which is quiet.
    warning_active <= 1'b1;
    reg_write(8'h00, 32'h0);
    reg_write(8'h04, 32'h54);
    repeat (3) @(posedge clk);
    chk(status_out_a, 1'b1);
    chk(status_out_b, 1'b1);
    speed_meas_rpm <= 13'h1324;
    reg_write(8'h04, 32'h3);
    repeat (3) @(posedge clk);
    chk(status_out_a, 1'b1);
    speed_meas_rpm <= 13'h1325;
    repeat (3) @(posedge clk);
    chk(status_out_a, 1'b0);
    for (int p = 1; p < 7; p += 5) begin
      reg_write(8'h08, 32'(p));
      reg_write(8'h04, 32'h1);
      repeat (3) @(posedge clk);
      prev = status_out_a;
      n_tog = 0;
      for (int i = 0; i < 360; i++) begin
        @(posedge clk);
        angle_tick <= 1'b1;
        @(posedge clk);
        angle_tick <= 1'b0;
        repeat (2) @(posedge clk);
        if (status_out_a !== prev) n_tog++;
        prev = status_out_a;
      end
      chk(n_tog, 2 * p);
    end
    reg_write(8'h04, 32'h0);
    drive_fault <= 1'b1;
    @(posedge clk);
    drive_fault <= 1'b0;
    repeat (3) @(posedge clk);
    chk(status_out_a, 1'b1);
    control_in <= 8'hE0;
    settle();
    control_in <= 8'hE4;
    settle();
    chk(status_out_a, 1'b0);
    chk(n_clear, 3);
    for (int a = 0; a < 16; a++) begin
      reg_write(8'h10, 32'(a));
      send_frame(8'(8'h30 + a), 8'h41);
      chk(n_end, a + 1);
    end
    chk(last_cmd, 8'h41);
    reply_byte <= 8'hA5;
    reply_valid <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (reply_ready !== 1'b1 && k < 100);
    reply_valid <= 1'b0;
    k = 0;
    while (i_mdsa_host_model.rx_count == 0 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    chk(i_mdsa_host_model.rx_byte, 8'hA5);
    repeat (2 * BITS) @(posedge clk);
    chk(ser_tx_oe_n, 1'b1);
    send_frame(8'h35, 8'h42);
    chk(n_end, 16);
    chk(reply_ready, 1'b0);
    chk(last_cmd, 8'h41);
    print_verdict();
  end
endmodule : mdsa_top_test
